/* core/dctm_sync.sv */
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module dctm_sync #(
    parameter int unsigned W = 2
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                // reset to energised so a healthy power-up reports no trip;
                // the real pin level is seen two clocks after release
                if (!rst_n)
                begin
                    meta_reg[i] <= 1'b1;
                    sync_out[i] <= 1'b1;
                end
                else
                begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

/* core/dctm_tick.sv */
// divider that makes a one-cycle enable pulse every DIV clocks
`timescale 1ns/100ps
`default_nettype none
module dctm_tick #(
    parameter int unsigned DIV = 25000
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    output var  logic tick
);

    localparam int unsigned CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] ZERO = '0;
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] cnt_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= ZERO;
            tick    <= 1'b0;
        end
        else if (cnt_reg == LAST)
        begin
            cnt_reg <= ZERO;
            tick    <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + ONE;
            tick    <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* core/dctm_top.sv */
// dual-channel torque-off monitor with discrepancy latch and feedback contacts
`timescale 1ns/100ps
`default_nettype none
module dctm_top
    import dctm_pkg::*;
#(
    parameter int unsigned WIN_CYC  = WINDOW_CYC,
    parameter int unsigned LIM_CYC  = LIMIT_CYC,
    parameter int unsigned RAMP_CYC = RAMP_DIV
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              demand_input_a,
    input  wire logic              demand_input_b,
    input  wire logic              run_cmd,
    input  wire logic              stop_cmd,
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic [DATA_W-1:0] bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output var  logic [DATA_W-1:0] bus_rdata,
    output var  logic              motor_torque_en,
    output var  logic [SPD_W-1:0]  motor_speed,
    output var  logic              trip_flag,
    output var  logic              fault_latch,
    output var  logic              feedback_contact_a,
    output var  logic              feedback_contact_b,
    output var  logic              irq
);

    localparam logic [CNT_W-1:0] WIN_LIM = CNT_W'(WIN_CYC);
    localparam logic [CNT_W-1:0] DISC_LIM = CNT_W'(LIM_CYC);

    dctm_state_s r;
    dctm_state_s n;
    dctm_bus_s   bus;

    logic [1:0] demand_sync;
    logic       ramp_tick;
    logic       a_ok;
    logic       b_ok;
    logic       one_low;
    logic       both_low;
    logic       any_low;
    logic       dual_valid;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    assign bus.addr  = bus_addr;
    assign bus.wdata = bus_wdata;
    assign bus.wr    = bus_wr;
    assign bus.rd    = bus_rd;

    // pins cross into the clock domain before anything looks at them
    dctm_sync #(
        .W (2)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({demand_input_b, demand_input_a}),
        .sync_out (demand_sync)
    );

    dctm_tick #(
        .DIV (RAMP_CYC)
    ) u_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (ramp_tick)
    );

    assign a_ok = demand_sync[0];
    assign b_ok = demand_sync[1];

    always_comb
    begin
        n        = r;
        ev_set   = EV_NONE;
        ev_clr   = EV_NONE;
        one_low  = a_ok ^ b_ok;
        both_low = !a_ok && !b_ok;
        any_low  = !a_ok || !b_ok;

        // time a single removed channel, frozen while both are removed
        if (a_ok && b_ok)
        begin
            n.disc_cnt = CNT_ZERO;
        end
        else if (one_low && (r.disc_cnt <= DISC_LIM))
        begin
            n.disc_cnt = r.disc_cnt + CNT_ONE;
        end

        // one channel removed beyond the limit latches the fault
        if (one_low && (r.disc_cnt > DISC_LIM))
        begin
            n.fault = 1'b1;
        end

        // both removed within the window of each other, no fault latched
        dual_valid = both_low && (r.disc_cnt <= WIN_LIM) && !r.fault;
        n.fb = dual_valid;

        if (any_low || r.fault || n.fault)
        begin
            // torque removed at once, motor coasts
            n.mode  = MODE_IDLE;
            n.speed = SPEED_ZERO;
            n.trip  = 1'b1;
        end
        else
        begin
            case (r.mode)
                MODE_IDLE:
                begin
                    if (run_cmd)
                    begin
                        n.trip = 1'b0;
                        if (r.setpoint != SETPOINT_RST)
                        begin
                            n.mode = MODE_RUN;
                        end
                    end
                end
                MODE_RUN:
                begin
                    if (stop_cmd)
                    begin
                        n.mode = MODE_DECEL;
                    end
                    else if (ramp_tick)
                    begin
                        if (r.speed < r.setpoint)
                        begin
                            n.speed = r.speed + SPEED_STEP;
                        end
                        else if (r.speed > r.setpoint)
                        begin
                            n.speed = r.speed - SPEED_STEP;
                        end
                    end
                end
                MODE_DECEL:
                begin
                    if (run_cmd)
                    begin
                        n.mode = MODE_RUN;
                    end
                    else if (ramp_tick)
                    begin
                        if (r.speed == SPEED_ZERO)
                        begin
                            n.mode = MODE_IDLE;
                        end
                        else
                        begin
                            n.speed = r.speed - SPEED_STEP;
                        end
                    end
                end
                default:
                begin
                    n.mode = MODE_IDLE;
                end
            endcase
        end

        n.torque = (n.mode != MODE_IDLE);

        // events for the interrupt status
        ev_set[EV_TRIP]     = n.trip && !r.trip;
        ev_set[EV_FAULT]    = n.fault && !r.fault;
        ev_set[EV_FB_CLOSE] = n.fb && !r.fb;
        ev_set[EV_FB_OPEN]  = !n.fb && r.fb;

        // register writes
        if (bus.wr)
        begin
            if (bus.addr == ADDR_SETPOINT)
            begin
                n.setpoint = bus.wdata[SPD_W-1:0];
            end
            else if (bus.addr == ADDR_IRQ_STAT)
            begin
                ev_clr = bus.wdata[EV_W-1:0];
            end
            else if (bus.addr == ADDR_IRQ_MASK)
            begin
                n.ev_mask = bus.wdata[EV_W-1:0];
            end
        end

        // a new event wins over a clear in the same cycle
        n.ev_stat = (r.ev_stat & ~ev_clr) | ev_set;
        n.irq     = |(n.ev_stat & n.ev_mask);

        // read data stand only in the cycle after the strobe
        n.rdata = DATA_ZERO;
        if (bus.rd)
        begin
            if (bus.addr == ADDR_SETPOINT)
            begin
                n.rdata[SPD_W-1:0] = r.setpoint;
            end
            else if (bus.addr == ADDR_STATUS)
            begin
                n.rdata[ST_TRIP]   = r.trip;
                n.rdata[ST_FAULT]  = r.fault;
                n.rdata[ST_FB]     = r.fb;
                n.rdata[ST_A_OK]   = a_ok;
                n.rdata[ST_B_OK]   = b_ok;
                n.rdata[ST_TORQUE] = r.torque;
                n.rdata[ST_DECEL]  = (r.mode == MODE_DECEL);
            end
            else if (bus.addr == ADDR_IRQ_STAT)
            begin
                n.rdata[EV_W-1:0] = r.ev_stat;
            end
            else if (bus.addr == ADDR_IRQ_MASK)
            begin
                n.rdata[EV_W-1:0] = r.ev_mask;
            end
            else if (bus.addr == ADDR_SPEED)
            begin
                n.rdata[SPD_W-1:0] = r.speed;
            end
            else if (bus.addr == ADDR_DISC_CNT)
            begin
                n.rdata[CNT_W-1:0] = r.disc_cnt;
            end
        end
    end

    // the fault latch has no clear but the power-on reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r.mode     <= MODE_IDLE;
            r.speed    <= SPEED_ZERO;
            r.setpoint <= SETPOINT_RST;
            r.disc_cnt <= CNT_ZERO;
            r.trip     <= 1'b0;
            r.fault    <= 1'b0;
            r.fb       <= 1'b0;
            r.torque   <= 1'b0;
            r.ev_stat  <= EV_NONE;
            r.ev_mask  <= EV_NONE;
            r.irq      <= 1'b0;
            r.rdata    <= DATA_ZERO;
        end
        else
        begin
            r <= n;
        end
    end

    assign bus_rdata          = r.rdata;
    assign motor_torque_en    = r.torque;
    assign motor_speed        = r.speed;
    assign trip_flag          = r.trip;
    assign fault_latch        = r.fault;
    assign feedback_contact_a = r.fb;
    assign feedback_contact_b = r.fb;
    assign irq                = r.irq;

endmodule
`default_nettype wire

/* include/dctm_pkg.sv */
// shared constants, types and register map of the torque-off monitor
package dctm_pkg;

    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned WINDOW_MS    = 1000;
    localparam int unsigned LIMIT_MS     = 3000;
    localparam int unsigned RAMP_STEP_US = 1000;
    localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
    localparam int unsigned WINDOW_CYC   = CYC_PER_MS * WINDOW_MS;
    localparam int unsigned LIMIT_CYC    = CYC_PER_MS * LIMIT_MS;
    localparam int unsigned RAMP_DIV     = (CLK_HZ / 1_000_000) * RAMP_STEP_US;

    localparam int unsigned CNT_W  = 28;
    localparam int unsigned SPD_W  = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned EV_W   = 4;

    localparam logic [ADDR_W-1:0] ADDR_SETPOINT = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_SPEED    = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_DISC_CNT = 8'h14;

    localparam int unsigned ST_TRIP   = 0;
    localparam int unsigned ST_FAULT  = 1;
    localparam int unsigned ST_FB     = 2;
    localparam int unsigned ST_A_OK   = 3;
    localparam int unsigned ST_B_OK   = 4;
    localparam int unsigned ST_TORQUE = 5;
    localparam int unsigned ST_DECEL  = 6;

    localparam int unsigned EV_TRIP    = 0;
    localparam int unsigned EV_FAULT   = 1;
    localparam int unsigned EV_FB_CLOSE = 2;
    localparam int unsigned EV_FB_OPEN = 3;

    localparam logic [SPD_W-1:0]  SETPOINT_RST = 16'h0000;
    localparam logic [SPD_W-1:0]  SPEED_ZERO   = 16'h0000;
    localparam logic [SPD_W-1:0]  SPEED_STEP   = 16'h0001;
    localparam logic [CNT_W-1:0]  CNT_ZERO     = 28'h0000000;
    localparam logic [CNT_W-1:0]  CNT_ONE      = 28'h0000001;
    localparam logic [EV_W-1:0]   EV_NONE      = 4'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO    = 32'h00000000;

    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_RUN,
        MODE_DECEL
    } dctm_mode_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } dctm_bus_s;

    typedef struct packed {
        dctm_mode_e        mode;
        logic [SPD_W-1:0]  speed;
        logic [SPD_W-1:0]  setpoint;
        logic [CNT_W-1:0]  disc_cnt;
        logic              trip;
        logic              fault;
        logic              fb;
        logic              torque;
        logic [EV_W-1:0]   ev_stat;
        logic [EV_W-1:0]   ev_mask;
        logic              irq;
        logic [DATA_W-1:0] rdata;
    } dctm_state_s;

endpackage

/* tb/dctm_assertions.sv */
// concurrent checks on the torque-off monitor ports
`timescale 1ns/100ps
`default_nettype none
module dctm_assertions
    import dctm_pkg::*;
#(
    parameter int unsigned LIM_CYC = 60
) (
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic              demand_input_a,
    input wire logic              demand_input_b,
    input wire logic              run_cmd,
    input wire logic              stop_cmd,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic              bus_wr,
    input wire logic              bus_rd,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic              motor_torque_en,
    input wire logic [SPD_W-1:0]  motor_speed,
    input wire logic              trip_flag,
    input wire logic              fault_latch,
    input wire logic              feedback_contact_a,
    input wire logic              feedback_contact_b,
    input wire logic              irq
);
    int unsigned one_low_cnt;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // counts pin-level cycles with exactly one channel removed
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            one_low_cnt <= 0;
        else if (demand_input_a ^ demand_input_b)
            one_low_cnt <= one_low_cnt + 1;
        else
            one_low_cnt <= 0;
    end

    sequence coast_s;
        !motor_torque_en && trip_flag && motor_speed == SPEED_ZERO;
    endsequence

    drop_a_coast_a: assert property ($fell(demand_input_a) |-> ##[1:4] coast_s)
        else $error("no coast after channel a drop");
    drop_b_coast_a: assert property ($fell(demand_input_b) |-> ##[1:4] coast_s)
        else $error("no coast after channel b drop");
    disc_limit_a: assert property (one_low_cnt > LIM_CYC + 6 |-> fault_latch)
        else $error("discrepancy not latched");
    fault_stop_a: assert property (fault_latch |-> !motor_torque_en && trip_flag)
        else $error("torque while fault latched");
    fault_keep_a: assert property (fault_latch |=> fault_latch)
        else $error("fault latch cleared without reset");
    fb_safe_a: assert property (feedback_contact_a |-> trip_flag && !motor_torque_en && !fault_latch)
        else $error("contacts closed while not safe");
    fb_open_a: assert property ($rose(demand_input_a) |-> ##[1:4] !feedback_contact_a)
        else $error("contacts not opened on restore");
    fb_pair_a: assert property (feedback_contact_a == feedback_contact_b)
        else $error("contact pair differs");
endmodule

bind dctm_top dctm_assertions #(.LIM_CYC(LIM_CYC)) i_dctm_assertions (
    .sys_clk(sys_clk), .rst_n(rst_n), .demand_input_a(demand_input_a), .demand_input_b(demand_input_b),
    .run_cmd(run_cmd), .stop_cmd(stop_cmd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .motor_torque_en(motor_torque_en),
    .motor_speed(motor_speed), .trip_flag(trip_flag), .fault_latch(fault_latch),
    .feedback_contact_a(feedback_contact_a), .feedback_contact_b(feedback_contact_b), .irq(irq));
`default_nettype wire

/* tb/dctm_partner.sv */
// model of the external safety unit driving both demand pins
`timescale 1ns/100ps
`default_nettype none
module dctm_partner (
    input  wire logic       sys_clk,
    input  wire logic [1:0] open_req,
    output var  logic       demand_input_a,
    output var  logic       demand_input_b
);
    initial {demand_input_a, demand_input_b} = 2'b11;

    // bench holds single drops briefly or past the discrepancy limit, and drops both close together
    always @(posedge sys_clk)
    begin
        demand_input_a <= !open_req[0];
        demand_input_b <= !open_req[1];
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the torque-off monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module tb_top
    import dctm_pkg::*;
;
    localparam int unsigned      LIM = 60;
    localparam logic [SPD_W-1:0] SPT = 16'h0005;
    logic              sys_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [1:0]        opn = 2'b00;
    logic              run_cmd = 1'b0;
    logic              stop_cmd = 1'b0;
    logic [ADDR_W-1:0] bus_addr = 8'h00;
    logic [DATA_W-1:0] bus_wdata = 32'h00000000;
    logic              bus_wr = 1'b0;
    logic              bus_rd = 1'b0;
    logic [DATA_W-1:0] bus_rdata;
    logic [SPD_W-1:0]  motor_speed;
    logic              pin_a, pin_b, motor_torque_en, trip_flag, fault_latch, fb_a, fb_b, irq;
    int                err_total = 0;
    int                check_count = 0;

    always #20 sys_clk = ~sys_clk;

    dctm_partner i_dctm_partner (.sys_clk(sys_clk), .open_req(opn), .demand_input_a(pin_a),
        .demand_input_b(pin_b));
    dctm_top #(.WIN_CYC(20), .LIM_CYC(LIM), .RAMP_CYC(4)) i_dctm_top (.sys_clk(sys_clk), .rst_n(rst_n),
        .demand_input_a(pin_a), .demand_input_b(pin_b), .run_cmd(run_cmd), .stop_cmd(stop_cmd),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .motor_torque_en(motor_torque_en), .motor_speed(motor_speed), .trip_flag(trip_flag),
        .fault_latch(fault_latch), .feedback_contact_a(fb_a), .feedback_contact_b(fb_b), .irq(irq));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic nt(int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic pins(logic [1:0] v);
        @(posedge sys_clk);
        opn <= v;
    endtask

    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(negedge sys_clk);
        d = bus_rdata;
    endtask

    task automatic go();
        @(posedge sys_clk);
        run_cmd <= 1'b1;
        repeat (2) @(posedge sys_clk);
        run_cmd <= 1'b0;
    endtask

    task automatic look(logic tq, logic tr, logic fb);
        `CHK("torque", tq, motor_torque_en)
        `CHK("trip", tr, trip_flag)
        `CHK("contact a", fb, fb_a)
        `CHK("contact b", fb, fb_b)
    endtask

    task automatic wait_speed(logic [SPD_W-1:0] s);
        int n;
        n = 0;
        while (motor_speed !== s && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("speed", s, motor_speed)
        if (n == 400)
            finish_test();
    endtask

    task automatic t_power();
        logic [DATA_W-1:0] d;
        nt(4);
        look(1'b0, 1'b0, 1'b0);
        rd(ADDR_SETPOINT, d);
        `CHK("setpoint", DATA_ZERO, d)
        rd(ADDR_STATUS, d);
        `CHK("status", 32'h00000018, d)
        wr(ADDR_SETPOINT, {16'h0000, SPT});
        go();
        wait_speed(SPT);
        look(1'b1, 1'b0, 1'b0);
        rd(ADDR_SPEED, d);
        `CHK("speed reg", {16'h0000, SPT}, d)
        $display("power-up test done");
    endtask

    task automatic t_short(logic [1:0] ch);
        pins(ch);
        nt(6);
        look(1'b0, 1'b1, 1'b0);
        `CHK("speed", SPEED_ZERO, motor_speed)
        pins(2'b00);
        nt(6);
        look(1'b0, 1'b1, 1'b0);
        go();
        wait_speed(SPT);
        look(1'b1, 1'b0, 1'b0);
        $display("short drop %b test done", ch);
    endtask

    task automatic t_both();
        logic [DATA_W-1:0] d;
        wr(ADDR_IRQ_STAT, 32'h0000000f);
        wr(ADDR_IRQ_MASK, 32'h00000000);
        pins(2'b01);
        nt(5);
        pins(2'b11);
        nt(6);
        look(1'b0, 1'b1, 1'b1);
        `CHK("irq masked", 1'b0, irq)
        rd(ADDR_IRQ_STAT, d);
        `CHK("irq status", 32'h00000005, d)
        wr(ADDR_IRQ_MASK, 32'h00000004);
        nt(2);
        `CHK("irq", 1'b1, irq)
        wr(ADDR_IRQ_STAT, 32'h00000004);
        nt(2);
        `CHK("irq cleared", 1'b0, irq)
        rd(8'h20, d);
        `CHK("unmapped", DATA_ZERO, d)
        @(posedge sys_clk);
        run_cmd <= 1'b1;
        nt(30);
        look(1'b0, 1'b1, 1'b1);
        @(posedge sys_clk);
        run_cmd <= 1'b0;
        pins(2'b00);
        nt(6);
        look(1'b0, 1'b1, 1'b0);
        go();
        wait_speed(SPT);
        look(1'b1, 1'b0, 1'b0);
        $display("two-channel stop test done");
    endtask

    task automatic t_fault(logic [1:0] ch);
        logic [DATA_W-1:0] d;
        pins(ch);
        nt(6);
        look(1'b0, 1'b1, 1'b0);
        nt(LIM + 10);
        `CHK("fault", 1'b1, fault_latch)
        rd(ADDR_STATUS, d);
        `CHK("fault status", {{27{1'b0}}, ~ch, 3'b011}, d)
        rd(ADDR_DISC_CNT, d);
        `CHK("disc count", 32'(LIM + 1), d)
        pins(2'b00);
        nt(6);
        go();
        nt(10);
        look(1'b0, 1'b1, 1'b0);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        nt(4);
        look(1'b0, 1'b0, 1'b0);
        `CHK("fault", 1'b0, fault_latch)
        wr(ADDR_SETPOINT, {16'h0000, SPT});
        go();
        wait_speed(SPT);
        $display("discrepancy %b test done", ch);
    endtask

    task automatic t_stop();
        logic [DATA_W-1:0] d;
        @(posedge sys_clk);
        stop_cmd <= 1'b1;
        @(posedge sys_clk);
        stop_cmd <= 1'b0;
        nt(2);
        look(1'b1, 1'b0, 1'b0);
        rd(ADDR_STATUS, d);
        `CHK("decel status", 32'h00000078, d)
        wait_speed(SPEED_ZERO);
        nt(6);
        look(1'b0, 1'b0, 1'b0);
        $display("ordinary stop test done");
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_power();
        t_short(2'b01);
        t_short(2'b10);
        t_both();
        t_fault(2'b01);
        t_fault(2'b10);
        t_stop();
        finish_test();
    end

    initial
    begin
        #4000000;
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
